// [hdl/lpm_mode_ctrl.v]
// operating-mode controller: clock gates, oscillator controls, wake and restore
// assumes the core pulses mode writes, interrupt entry and return in one cycle each
`include "lpm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module lpm_mode_ctrl (
    input  wire                   clk_i,
    input  wire                   rst_i,
    input  wire                   mode_wr_i,
    input  wire [`LPM_SR_W-1:0]   mode_bits_i,
    input  wire                   irq_enter_i,
    input  wire                   irq_return_i,
    input  wire                   vec_valid_i,
    input  wire [`LPM_VEC_W-1:0]  reset_vec_i,
    input  wire                   osc_used_in_run_i,
    output reg  [`LPM_ST_W-1:0]   full_run_state_o,
    output reg  [`LPM_SR_W-1:0]   mode_bits_o,
    output reg                    cpu_run_o,
    output reg                    main_clk_en_o,
    output reg                    subsystem_main_clock_en_o,
    output reg                    aux_clk_en_o,
    output reg                    digital_osc_dc_en_o,
    output reg                    xtal_en_o,
    output reg                    boot_fetch_en_o
);

////////////////////////////////////////////////////////////////////////////
reg [`LPM_SR_W-1:0] sr;
reg [`LPM_SR_W-1:0] saved_sr;
reg                 in_handler;
reg                 boot_done;
reg [`LPM_ST_W-1:0] next_state;
reg [`LPM_SR_W-1:0] next_sr;
reg                 take_boot;
reg                 take_enter;
reg                 take_return;
reg                 take_write;
reg                 blank_vec;
reg                 next_cpu_run;
reg                 next_main_clk_en;
reg                 next_sub_clk_en;
reg                 next_aux_clk_en;
reg                 next_dc_en;
reg                 next_xtal_en;

// one-hot state from mode bits; cpu off clear maps to run, osc off with cpu off to level four
function [`LPM_ST_W-1:0] lpm_decode;
    input [`LPM_SR_W-1:0] b;
    begin
        if (!b[`LPM_SR_CPUOFF])
            lpm_decode = `LPM_ST_RUN;
        else if (b[`LPM_SR_OSCOFF])
            lpm_decode = `LPM_ST_L4;
        else begin
            case ({b[`LPM_SR_SCG1], b[`LPM_SR_SCG0]})
                2'h0:    lpm_decode = `LPM_ST_L0;
                2'h1:    lpm_decode = `LPM_ST_L1;
                2'h2:    lpm_decode = `LPM_ST_L2;
                default: lpm_decode = `LPM_ST_L3;
            endcase
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// request decode; entry beats return, return beats a plain write
always @* begin
    take_boot   = !boot_done && vec_valid_i;
    blank_vec   = (reset_vec_i == `LPM_VEC_BLANK);
    take_enter  = boot_done && irq_enter_i;
    take_return = boot_done && !irq_enter_i && irq_return_i && in_handler;
    take_write  = boot_done && !irq_enter_i && !take_return && mode_wr_i;
end

////////////////////////////////////////////////////////////////////////////
// vector seen once; nothing else is taken before it
always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        boot_done <= 1'b0;
    end else if (take_boot) begin
        boot_done <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// next mode bits
always @* begin
    next_sr = sr;
    if (take_boot && blank_vec) begin
        next_sr = `LPM_SR_LVL4;
    end else if (take_enter) begin
        next_sr = `LPM_SR_RESET;
    end else if (take_return) begin
        next_sr = saved_sr;
    end else if (take_write) begin
        next_sr = mode_bits_i;
    end
end

// mode bits
always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        sr <= `LPM_SR_RESET;
    end else begin
        sr <= next_sr;
    end
end

// single saved copy: a nested entry overwrites it
always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        saved_sr   <= `LPM_SR_RESET;
        in_handler <= 1'b0;
    end else if (take_enter) begin
        saved_sr   <= sr;
        in_handler <= 1'b1;
    end else if (take_return) begin
        in_handler <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// gate decode; stopped unless a level keeps a clock alive
always @* begin
    next_state       = lpm_decode(sr);
    next_cpu_run     = 1'b0;
    next_main_clk_en = 1'b0;
    next_sub_clk_en  = 1'b0;
    next_aux_clk_en  = 1'b0;
    next_dc_en       = 1'b0;
    next_xtal_en     = 1'b0;
    case (next_state)
        `LPM_ST_RUN: begin
            next_cpu_run     = boot_done;
            next_main_clk_en = 1'b1;
            next_sub_clk_en  = 1'b1;
            next_aux_clk_en  = 1'b1;
            next_dc_en       = 1'b1;
            next_xtal_en     = 1'b1;
        end

        `LPM_ST_L0: begin
            next_cpu_run     = 1'b0;
            next_main_clk_en = 1'b0;
            next_sub_clk_en  = 1'b1;
            next_aux_clk_en  = 1'b1;
            next_dc_en       = 1'b1;
            next_xtal_en     = 1'b1;
        end

        `LPM_ST_L1: begin
            next_cpu_run     = 1'b0;
            next_main_clk_en = 1'b0;
            next_sub_clk_en  = 1'b1;
            next_aux_clk_en  = 1'b1;
            next_dc_en       = osc_used_in_run_i;
            next_xtal_en     = 1'b1;
        end

        `LPM_ST_L2: begin
            next_cpu_run     = 1'b0;
            next_main_clk_en = 1'b0;
            next_sub_clk_en  = 1'b0;
            next_aux_clk_en  = 1'b1;
            next_dc_en       = 1'b1;
            next_xtal_en     = 1'b1;
        end

        `LPM_ST_L3: begin
            next_cpu_run     = 1'b0;
            next_main_clk_en = 1'b0;
            next_sub_clk_en  = 1'b0;
            next_aux_clk_en  = 1'b1;
            next_dc_en       = 1'b0;
            next_xtal_en     = 1'b1;
        end

        default: begin
            next_cpu_run     = 1'b0;
            next_main_clk_en = 1'b0;
            next_sub_clk_en  = 1'b0;
            next_aux_clk_en  = 1'b0;
            next_dc_en       = 1'b0;
            next_xtal_en     = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////
// gates registered so each output comes from a flop; one cycle behind sr
always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        full_run_state_o          <= `LPM_ST_RUN;
        mode_bits_o               <= `LPM_SR_RESET;
        cpu_run_o                 <= 1'b0;
        main_clk_en_o             <= 1'b1;
        subsystem_main_clock_en_o <= 1'b1;
        aux_clk_en_o              <= 1'b1;
        digital_osc_dc_en_o       <= 1'b1;
        xtal_en_o                 <= 1'b1;
        boot_fetch_en_o           <= 1'b0;
    end else begin
        full_run_state_o          <= next_state;
        mode_bits_o               <= sr;
        boot_fetch_en_o           <= boot_done;
        cpu_run_o                 <= next_cpu_run;
        main_clk_en_o             <= next_main_clk_en;
        subsystem_main_clock_en_o <= next_sub_clk_en;
        aux_clk_en_o              <= next_aux_clk_en;
        digital_osc_dc_en_o       <= next_dc_en;
        xtal_en_o                 <= next_xtal_en;
    end
end

endmodule

`default_nettype wire

// [hdl/lpm_defines.vh]
// constants for the operating-mode controller
// assumes a single 40 MHz clock and mode bits driven by the cpu core
//
// How it works
// - one run state plus five software sleep levels
// - run state keeps every clock running
// - level zero: cpu halted, aux and subsystem run
// - level one adds dc generator off if unused
// - level two gates main and subsystem, generator on
// - level three: only auxiliary clock left running
// - level four stops everything, crystal included
// - interrupt wakes; return re-enters saved level
// - blank reset vector forces level four at power-up
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH

// status mode bits: cpu off, osc off, scg0, scg1
`define LPM_SR_CPUOFF    0
`define LPM_SR_OSCOFF    1
`define LPM_SR_SCG0      2
`define LPM_SR_SCG1      3
`define LPM_SR_W         4
`define LPM_SR_RESET     4'h0

`define LPM_SR_LVL0      4'h1
`define LPM_SR_LVL1      4'h5
`define LPM_SR_LVL2      4'h9
`define LPM_SR_LVL3      4'hd
`define LPM_SR_LVL4      4'hf

`define LPM_VEC_W        16
`define LPM_VEC_BLANK    16'hffff

`define LPM_ST_W         6
`define LPM_ST_RUN       6'h01
`define LPM_ST_L0        6'h02
`define LPM_ST_L1        6'h04
`define LPM_ST_L2        6'h08
`define LPM_ST_L3        6'h10
`define LPM_ST_L4        6'h20

`endif

// [verif/lpm_mode_ctrl_sva.sv]
// checker on the controller ports
// assumes bind onto lpm_mode_ctrl
`timescale 1ns/1ps
`default_nettype none
module lpm_mode_ctrl_sva (
    input wire logic clk_i, rst_i, mode_wr_i, irq_enter_i, irq_return_i, vec_valid_i,
    input wire logic osc_used_in_run_i, boot_fetch_en_o, cpu_run_o, main_clk_en_o,
    input wire logic subsystem_main_clock_en_o, aux_clk_en_o, digital_osc_dc_en_o, xtal_en_o,
    input wire logic [3:0] mode_bits_i, mode_bits_o,
    input wire logic [15:0] reset_vec_i,
    input wire logic [5:0] full_run_state_o
);
    wire [5:0] st = full_run_state_o;
    wire [5:0] en = {cpu_run_o, main_clk_en_o, subsystem_main_clock_en_o, aux_clk_en_o,
                     digital_osc_dc_en_o, xtal_en_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_run_on:
        assert property (st == 6'h01 |-> en[4:0] == 5'h1f) else $error("run gated");
    a_lvl0_gate:
        assert property (st == 6'h02 |-> en == 6'h0f) else $error("level 0 gates");
    a_lvl1_dc:
        assert property (st == 6'h04 |-> {en[5:2], en[0]} == 5'h07
            && en[1] == $past(osc_used_in_run_i)) else $error("level 1 gates");
    a_lvl2_gate:
        assert property (st == 6'h08 |-> en == 6'h07) else $error("level 2 gates");
    a_lvl3_aux:
        assert property (st == 6'h10 |-> en == 6'h05) else $error("level 3 gates");
    a_lvl4_stop:
        assert property (st == 6'h20 |-> en == 6'h00) else $error("level 4 gates");
    a_irq_wake:
        assert property (irq_enter_i && boot_fetch_en_o |-> ##2 st == 6'h01 && cpu_run_o)
            else $error("no wake");
    a_mode_take:
        assert property (mode_wr_i && !irq_enter_i && !irq_return_i && boot_fetch_en_o
            |-> ##2 mode_bits_o == $past(mode_bits_i, 2)) else $error("mode not taken");
    a_boot_blank:
        assert property (vec_valid_i && reset_vec_i == 16'hffff && !boot_fetch_en_o
            |-> ##2 st == 6'h20) else $error("blank vector");
endmodule
`default_nettype wire

// [verif/lpm_core_model.sv]
// core model: reset vector word and handler entry, return
// assumes the controller shares its clock
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
    input  wire logic        clk_i, rst_i, blank_i, svc_i,
    output var  logic        vec_valid_o, enter_o, ret_o,
    output wire logic [15:0] vec_o
);
    logic [2:0] cnt;
    assign vec_o = blank_i ? 16'hffff : 16'h4400;
    always @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {vec_valid_o, enter_o, ret_o, cnt} <= 6'h00;
        end else begin
            vec_valid_o <= 1'b1;
            enter_o <= svc_i;
            // late return so the woken state can be seen
            ret_o <= cnt == 3'd1;
            cnt <= svc_i ? 3'd5 : cnt - {2'b0, cnt != 3'd0};
        end
    end
endmodule
`default_nettype wire

// [verif/lpm_mode_ctrl_tb.sv]
// self-checking bench for the operating-mode controller
// assumes the core model supplies vector and handler pulses
`timescale 1ns/1ps
`default_nettype none
module lpm_mode_ctrl_tb;
    logic clk_i = 0, rst_i = 1, mode_wr_i = 0, osc_used_in_run_i = 0, blank = 0, svc = 0;
    logic [3:0] mode_bits_i = 0, mode_bits_o;
    logic [5:0] full_run_state_o;
    logic [15:0] reset_vec_i;
    logic vec_valid_i, irq_enter_i, irq_return_i, boot_fetch_en_o, cpu_run_o, main_clk_en_o;
    logic subsystem_main_clock_en_o, aux_clk_en_o, digital_osc_dc_en_o, xtal_en_o;
    int fails = 0, checked = 0, cyc = 0;
    logic [19:0] rows [8] = '{20'h0007f, 20'h1008f, 20'h5010d, 20'h5110f,
                             20'h90207, 20'hd0405, 20'hf0800, 20'h0007f};
    wire [16:0] obs = {boot_fetch_en_o, mode_bits_o, full_run_state_o, cpu_run_o, main_clk_en_o,
                       subsystem_main_clock_en_o, aux_clk_en_o, digital_osc_dc_en_o, xtal_en_o};
    lpm_mode_ctrl i_dut (.*);
    lpm_core_model i_core (.clk_i, .rst_i, .blank_i(blank), .svc_i(svc), .vec_valid_o(vec_valid_i),
                           .enter_o(irq_enter_i), .ret_o(irq_return_i), .vec_o(reset_vec_i));
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cyc > 400) begin fails++; end_of_test; end
    task chk(input logic [16:0] exp);
        checked++;
        if (obs !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, obs, exp);
        end
    endtask
    task wr(input logic [3:0] b);
        mode_wr_i <= 1;
        mode_bits_i <= b;
        @(negedge clk_i) mode_wr_i <= 0;
        repeat (2) @(negedge clk_i);
    endtask
    // a refused write rides on the entry edge
    task wake(input logic [16:0] during, after);
        svc <= 1;
        @(negedge clk_i) begin svc <= 0; mode_wr_i <= 1; mode_bits_i <= 4'h1; end
        @(negedge clk_i) mode_wr_i <= 0;
        repeat (2) @(negedge clk_i);
        chk(during);
        repeat (6) @(negedge clk_i);
        chk(after);
    endtask
    task end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i <= 0;
        repeat (4) @(negedge clk_i);
        chk(17'h1007f);
        $display("test boot done");
        foreach (rows[i]) begin
            osc_used_in_run_i <= rows[i][12];
            wr(rows[i][19:16]);
            chk({1'b1, rows[i][19:16], rows[i][11:0]});
        end
        $display("test levels done");
        wr(4'hd);
        wake(17'h1007f, 17'h1d405);
        $display("test wake done");
        blank <= 1;
        rst_i <= 1;
        repeat (8) @(negedge clk_i);
        rst_i <= 0;
        repeat (4) @(negedge clk_i);
        chk(17'h1f800);
        wake(17'h1007f, 17'h1f800);
        $display("test blank vector done");
        end_of_test;
    end
endmodule
bind lpm_mode_ctrl lpm_mode_ctrl_sva i_sva (.*);
`default_nettype wire
